// ===== rtl/seq_pkg.sv
/*
 Shared constants and types for the program sequencer: data memory
 indices, vectors, widths and the command and interrupt carriers.
 Assumes a core that issues one decoded command per instruction cycle.
*/
`default_nettype none
package seq_pkg;
    localparam int PC_W = 13;
    localparam int BANK_W = 4;
    localparam int WADDR_W = 17;
    localparam int BADDR_W = 18;
    localparam int SAMPLE_LSB = 5;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int DMEM_SIZE = 256;

    localparam logic [12:0] RESET_PC = 13'h0000;
    localparam logic [3:0] RESET_BANK = 4'h0;
    localparam logic [12:0] VEC_TMR0 = 13'h0008;
    localparam logic [12:0] VEC_TMR1 = 13'h000c;
    localparam logic [4:0] LAST_PAGE = 5'h1f;
    localparam logic [4:0] SAMPLE_PAD = 5'h00;
    localparam logic [12:0] PC_STEP = 13'h0001;
    localparam logic [12:0] PC_SKIP = 13'h0002;

    // Register indices; byte address on APB is four times the index
    localparam logic [7:0] IDX_IND0 = 8'h00;
    localparam logic [7:0] IDX_PTR0 = 8'h01;
    localparam logic [7:0] IDX_IND1 = 8'h02;
    localparam logic [7:0] IDX_PTR1 = 8'h03;
    localparam logic [7:0] IDX_BANK = 8'h04;
    localparam logic [7:0] IDX_PCL = 8'h06;
    localparam logic [7:0] IDX_TABLE_POINTER = 8'h07;
    localparam logic [7:0] IDX_TABLE_HIGH_BYTE = 8'h08;
    localparam logic [7:0] WAVE_LO = 8'h20;
    localparam logic [7:0] WAVE_HI = 8'h2a;
    localparam logic [7:0] GP_LO = 8'h30;
    localparam logic [7:0] READ_ZERO = 8'h00;

    typedef enum logic [3:0] {
        OP_NEXT = 4'h0,
        OP_JUMP = 4'h1,
        OP_CALL = 4'h2,
        OP_RET = 4'h3,
        OP_RETURN_INT = 4'h4,
        OP_SKIP = 4'h5,
        OP_TABLE_READ_CURRENT_PAGE = 4'h6,
        OP_TABLE_READ_LAST_PAGE = 4'h7,
        OP_BSET = 4'h8,
        OP_BCLR = 4'h9
    } op_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DUMMY = 2'b01,
        ST_TABLE = 2'b10
    } state_t;

    typedef struct packed {
        op_t op;
        logic [12:0] operand;
        logic [7:0] dest;
        logic [2:0] bit_idx;
    } seq_cmd_t;

    typedef struct packed {
        logic master_en;
        logic t0_req;
        logic t0_en;
        logic t1_req;
        logic t1_en;
    } irq_req_t;
endpackage
`default_nettype wire

// ===== rtl/prog_sequencer.sv
/*
 Program sequencer with bank select, return stack, table reads,
 wavetable start mapping and the 256-byte data memory map over APB.
 Assumes the core decodes instructions and presents one command per
 instruction cycle, and that the ROM answers combinationally.
*/
// Our own choice: the APB interface to the registers.
// Function
// (RULE1) Reset clears counter and bank to zero
// (RULE2) Timer 0 acknowledge jumps to 008H
// (RULE3) Timer 1 acknowledge jumps to 00CH
// (RULE4) Word address is bank then counter
// (RULE5) Jump and call load operand bits
// (RULE6) Return restores counter from stack top
// (RULE7) Table address: page or last page
// (RULE8) Table low byte to memory, high byte
// (RULE9) Table read takes two cycles
// (RULE10) Bank write applies after next instruction
// (RULE11) Sixteen banks of 8192 words
// (RULE12) Sample start drives bits 17..5, zeros below
// (RULE13) Sample addresses in bytes, program in words
// (RULE14) Eight-entry stack, hidden from software
// (RULE15) Push on call or acknowledge, pop on return
// (RULE16) Reset points stack index at top
// (RULE17) Full stack holds off interrupt acknowledge
// (RULE18) Call on full stack drops oldest entry
// (RULE19) Wavetable 20H-2AH, other low spots read zero
// (RULE20) General memory 30H through FFH
// (RULE21) Every memory bit set or cleared
// (RULE22) Indirect access through two pointers
// (RULE23) Low byte write makes short jump
// (RULE24) Met skip adds two with dummy cycle
`timescale 1ns/1ns
`default_nettype none
module prog_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire seq_pkg::seq_cmd_t cmd,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire seq_pkg::irq_req_t irq,
    output logic [1:0] irq_ack,
    input wire logic [15:0] rom_data,
    input wire logic [12:0] sample_start_addr,
    output logic [16:0] rom_word_addr_lines,
    output logic [17:0] rom_byte_addr_lines,
    output logic [12:0] prog_counter_bits,
    output logic [3:0] bank_select_bits
);
    seq_pkg::state_t state_ff, nxt_state;
    logic [12:0] pc_ff, nxt_pc;
    logic [3:0] bank_ff, nxt_bank, bank_pend_ff;
    logic bank_arm_ff;
    logic [12:0] stk_ff [seq_pkg::STACK_DEPTH];
    logic [2:0] sp_ff;
    logic [3:0] depth_ff;
    logic [7:0] mem_ff [seq_pkg::DMEM_SIZE];
    logic [7:0] table_high_byte_ff, tdest_ff;
    logic [16:0] waddr_ff, nxt_waddr;
    logic [17:0] baddr_ff;
    logic [31:0] prdata_ff;
    logic rd_ok_ff;
    logic stk_full, irq_go, irq_t0, take, push, pop;
    logic [12:0] push_val, stk_top;
    logic [16:0] tbl_addr;
    logic instr_end, apb_fire, apb_wr, bad_addr, pcl_wr, bank_wr;
    logic [7:0] a_idx, a_eff, d_idx, d_eff, a_rd;
    logic is_bitop, is_tab;
    // Bank select and counter form the fetch address except in a table cycle, which uses the table address
    assign prog_counter_bits = pc_ff;
    assign bank_select_bits = bank_ff;
    assign rom_word_addr_lines = waddr_ff;
    assign rom_byte_addr_lines = baddr_ff;
    assign prdata = prdata_ff;

    // APB decode; each byte of data memory takes one word
    assign a_idx = paddr[9:2];
    assign bad_addr = (paddr[1:0] != 2'b00) || (paddr[11:10] != 2'b00);
    // Wait out a table cycle so read data is never stale
    assign pready = clk_en && rd_ok_ff && (state_ff != seq_pkg::ST_TABLE);
    assign apb_fire = psel && penable && pready;
    assign pslverr = apb_fire && bad_addr;
    assign apb_wr = apb_fire && pwrite && !bad_addr;
    assign pcl_wr = apb_wr && (a_idx == seq_pkg::IDX_PCL);
    assign bank_wr = apb_wr && (a_idx == seq_pkg::IDX_BANK);

    // One level of indirection; a pointer at 00H or 02H lands nowhere
    function automatic logic [7:0] resolve(input logic [7:0] idx,
            input logic [7:0] p0, input logic [7:0] p1);
        if (idx == seq_pkg::IDX_IND0) begin
            resolve = p0;
        end else if (idx == seq_pkg::IDX_IND1) begin
            resolve = p1;
        end else begin
            resolve = idx;
        end
    endfunction

    function automatic logic writable(input logic [7:0] idx);
        writable = (idx == seq_pkg::IDX_PTR0) ||
            (idx == seq_pkg::IDX_PTR1) ||
            (idx == seq_pkg::IDX_TABLE_POINTER) ||
            (idx >= seq_pkg::WAVE_LO && idx <= seq_pkg::WAVE_HI) ||
            (idx >= seq_pkg::GP_LO);
    endfunction

    assign a_eff = resolve(a_idx, mem_ff[seq_pkg::IDX_PTR0],
        mem_ff[seq_pkg::IDX_PTR1]); // RULE22
    assign d_idx = (state_ff == seq_pkg::ST_TABLE) ? tdest_ff : cmd.dest;
    assign d_eff = resolve(d_idx, mem_ff[seq_pkg::IDX_PTR0],
        mem_ff[seq_pkg::IDX_PTR1]); // RULE22

    // Read map: hidden stack and write-only bank read as zero
    always_comb begin
        if (a_eff == seq_pkg::IDX_PCL) begin
            a_rd = pc_ff[7:0];
        end else if (a_eff == seq_pkg::IDX_TABLE_HIGH_BYTE) begin
            a_rd = table_high_byte_ff;
        end else if (writable(a_eff)) begin
            a_rd = mem_ff[a_eff];
        end else begin
            a_rd = seq_pkg::READ_ZERO; // RULE19 RULE14
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            rd_ok_ff <= 1'b0;
        end else if (clk_en) begin
            rd_ok_ff <= psel && (state_ff != seq_pkg::ST_TABLE);
            if (psel) begin
                prdata_ff <= bad_addr ? 32'h0000_0000 : {24'h000000, a_rd};
            end
        end
    end

    // Sequencing; APB traffic pauses the core so pc and memory agree
    assign stk_full = (depth_ff == 4'(seq_pkg::STACK_DEPTH));
    assign irq_t0 = irq.t0_req && irq.t0_en;
    assign irq_go = (state_ff == seq_pkg::ST_RUN) && !psel &&
        irq.master_en && (irq_t0 || (irq.t1_req && irq.t1_en)) &&
        !stk_full; // RULE17
    assign irq_ack = (clk_en && irq_go) ? {!irq_t0, irq_t0} : 2'b00;
    assign cmd_ready = clk_en && (state_ff == seq_pkg::ST_RUN) &&
        !psel && !irq_go;
    assign take = cmd_valid && cmd_ready;
    assign is_bitop = (cmd.op == seq_pkg::OP_BSET) ||
        (cmd.op == seq_pkg::OP_BCLR);
    assign is_tab = (cmd.op == seq_pkg::OP_TABLE_READ_CURRENT_PAGE) ||
        (cmd.op == seq_pkg::OP_TABLE_READ_LAST_PAGE);
    assign stk_top = stk_ff[sp_ff - 3'd1];
    assign tbl_addr = {bank_ff,
        (cmd.op == seq_pkg::OP_TABLE_READ_LAST_PAGE) ? seq_pkg::LAST_PAGE : pc_ff[12:8],
        mem_ff[seq_pkg::IDX_TABLE_POINTER]}; // RULE7

    always_comb begin
        nxt_pc = pc_ff;
        nxt_state = state_ff;
        push = 1'b0;
        pop = 1'b0;
        push_val = pc_ff;
        case (state_ff)
            seq_pkg::ST_RUN: begin
                if (irq_go) begin
                    push = 1'b1; // RULE15
                    nxt_pc = irq_t0 ? seq_pkg::VEC_TMR0 : // RULE2
                        seq_pkg::VEC_TMR1; // RULE3
                    nxt_state = seq_pkg::ST_DUMMY;
                end else if (take) begin
                    case (cmd.op)
                        seq_pkg::OP_JUMP: begin
                            nxt_pc = cmd.operand; // RULE5
                            nxt_state = seq_pkg::ST_DUMMY;
                        end
                        seq_pkg::OP_CALL: begin
                            push = 1'b1; // RULE15
                            push_val = pc_ff + seq_pkg::PC_STEP;
                            nxt_pc = cmd.operand; // RULE5
                            nxt_state = seq_pkg::ST_DUMMY;
                        end
                        seq_pkg::OP_RET, seq_pkg::OP_RETURN_INT: begin
                            pop = 1'b1; // RULE15
                            nxt_pc = stk_top; // RULE6
                            nxt_state = seq_pkg::ST_DUMMY;
                        end
                        seq_pkg::OP_SKIP: begin
                            nxt_pc = pc_ff + seq_pkg::PC_SKIP; // RULE24
                            nxt_state = seq_pkg::ST_DUMMY;
                        end
                        seq_pkg::OP_TABLE_READ_CURRENT_PAGE, seq_pkg::OP_TABLE_READ_LAST_PAGE: begin
                            nxt_pc = pc_ff + seq_pkg::PC_STEP;
                            nxt_state = seq_pkg::ST_TABLE; // RULE9
                        end
                        default: begin
                            nxt_pc = pc_ff + seq_pkg::PC_STEP;
                        end
                    endcase
                end
            end
            seq_pkg::ST_DUMMY, seq_pkg::ST_TABLE: nxt_state = seq_pkg::ST_RUN;
            default: nxt_state = seq_pkg::ST_RUN;
        endcase
        if (pcl_wr) begin
            nxt_pc = {pc_ff[12:8], pwdata[7:0]}; // RULE23
            nxt_state = seq_pkg::ST_DUMMY;
        end
    end

    // An instruction ends at its last cycle, dummy or table included
    assign instr_end = clk_en && ((take && nxt_state == seq_pkg::ST_RUN) ||
        (state_ff != seq_pkg::ST_RUN));
    assign nxt_bank = (bank_arm_ff && instr_end) ? bank_pend_ff : bank_ff;
    assign nxt_waddr = (nxt_state == seq_pkg::ST_TABLE) ? tbl_addr :
        {nxt_bank, nxt_pc}; // RULE4 RULE11

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= seq_pkg::ST_RUN;
            pc_ff <= seq_pkg::RESET_PC; // RULE1
            waddr_ff <= {seq_pkg::RESET_BANK, seq_pkg::RESET_PC};
        end else if (clk_en) begin
            state_ff <= nxt_state;
            pc_ff <= nxt_pc;
            waddr_ff <= nxt_waddr;
        end
    end

    // Bank write waits for the next instruction to finish
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_ff <= seq_pkg::RESET_BANK; // RULE1
            bank_pend_ff <= seq_pkg::RESET_BANK;
            bank_arm_ff <= 1'b0;
        end else if (clk_en) begin
            bank_ff <= nxt_bank; // RULE10
            if (bank_wr) begin
                bank_pend_ff <= pwdata[3:0];
                bank_arm_ff <= 1'b1;
            end else if (instr_end) begin
                bank_arm_ff <= 1'b0;
            end
        end
    end

    // Circular stack: overflow silently replaces the oldest entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_ff <= 3'd0; // RULE16
            depth_ff <= 4'd0;
            for (int i = 0; i < seq_pkg::STACK_DEPTH; i++) begin
                stk_ff[i] <= seq_pkg::RESET_PC;
            end
        end else if (clk_en) begin
            if (push) begin
                stk_ff[sp_ff] <= push_val; // RULE18
                sp_ff <= sp_ff + 3'd1;
                if (!stk_full) begin
                    depth_ff <= depth_ff + 4'd1; // RULE14
                end
            end else if (pop) begin
                sp_ff <= sp_ff - 3'd1;
                if (depth_ff != 4'd0) begin
                    depth_ff <= depth_ff - 4'd1;
                end
            end
        end
    end

    // Table capture and wavetable start address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_high_byte_ff <= 8'h00;
            tdest_ff <= 8'h00;
            baddr_ff <= 18'h00000;
        end else if (clk_en) begin
            baddr_ff <= {sample_start_addr, seq_pkg::SAMPLE_PAD}; // RULE12 RULE13
            if (take && is_tab) begin
                tdest_ff <= cmd.dest;
            end
            if (state_ff == seq_pkg::ST_TABLE) begin
                table_high_byte_ff <= rom_data[15:8]; // RULE8
            end
        end
    end

    // Data memory; unmapped cells are never written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < seq_pkg::DMEM_SIZE; i++) begin
                mem_ff[i] <= 8'h00;
            end
        end else if (clk_en) begin
            if (state_ff == seq_pkg::ST_TABLE && writable(d_eff)) begin
                mem_ff[d_eff] <= rom_data[7:0]; // RULE8
            end else if (take && is_bitop && writable(d_eff)) begin
                mem_ff[d_eff][cmd.bit_idx] <=
                    (cmd.op == seq_pkg::OP_BSET); // RULE21
            end else if (apb_wr && writable(a_eff)) begin
                mem_ff[a_eff] <= pwdata[7:0]; // RULE20 RULE19
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_vec_tmr0: assert property ( // RULE2
        clk_en && irq_go && irq_t0 |=> pc_ff == seq_pkg::VEC_TMR0 &&
            bank_ff == $past(bank_ff))
        else $error("timer 0 vector not taken");
    a_vec_tmr1: assert property ( // RULE3
        clk_en && irq_go && !irq_t0 |=> pc_ff == seq_pkg::VEC_TMR1)
        else $error("timer 1 vector not taken");
    a_word_addr: assert property ( // RULE4
        state_ff != seq_pkg::ST_TABLE |->
            rom_word_addr_lines == {bank_ff, pc_ff})
        else $error("word address not bank and counter");
    a_jump_load: assert property ( // RULE5
        take && cmd.op == seq_pkg::OP_JUMP |=>
            pc_ff == $past(cmd.operand) && bank_ff == $past(bank_ff))
        else $error("jump target wrong");
    a_return_pop: assert property ( // RULE6
        take && cmd.op == seq_pkg::OP_RET |=> pc_ff == $past(stk_top))
        else $error("return address wrong");
    a_last_page: assert property ( // RULE7
        take && cmd.op == seq_pkg::OP_TABLE_READ_LAST_PAGE |=>
            rom_word_addr_lines[12:8] == seq_pkg::LAST_PAGE &&
            rom_word_addr_lines[7:0] == $past(mem_ff[seq_pkg::IDX_TABLE_POINTER]))
        else $error("last page table address wrong");
    a_table_high: assert property ( // RULE8
        clk_en && state_ff == seq_pkg::ST_TABLE |=>
            table_high_byte_ff == $past(rom_data[15:8]))
        else $error("table high byte not captured");
    a_table_two: assert property ( // RULE9
        take && is_tab |=> state_ff == seq_pkg::ST_TABLE ##1
            (!clk_en || state_ff == seq_pkg::ST_RUN))
        else $error("table read not two cycles");
    a_bank_delay: assert property ( // RULE10
        clk_en && bank_wr |=> bank_ff == $past(bank_ff))
        else $error("bank changed at once");
    a_sample_addr: assert property ( // RULE12
        clk_en |=> rom_byte_addr_lines ==
            {$past(sample_start_addr), 5'h00})
        else $error("sample address wrong");
    a_full_hold: assert property ( // RULE17
        stk_full |-> irq_ack == 2'b00)
        else $error("acknowledge with full stack");
    a_skip_two: assert property ( // RULE24
        take && cmd.op == seq_pkg::OP_SKIP |=>
            pc_ff == 13'($past(pc_ff) + 13'h0002) &&
            state_ff == seq_pkg::ST_DUMMY)
        else $error("skip did not advance by two");
    c_table_read: cover property (take && is_tab ##1 clk_en);
    c_irq_ack: cover property (irq_ack != 2'b00);
    c_call_full: cover property (take && cmd.op == seq_pkg::OP_CALL &&
        stk_full);
    c_pcl_jump: cover property (pcl_wr);
endmodule
`default_nettype wire

// ===== tb/rom_model.sv
/*
 Behavioural model of the shared program and wavetable ROM.
 Assumes the sequencer reads it combinationally by word address.
*/
`timescale 1ns/1ns
`default_nettype none
module rom_model (
    input wire logic [16:0] word_addr,
    output logic [15:0] data
);
    // Contents follow the address so every read is predictable
    assign data = word_addr[15:0] ^ {word_addr[16], 15'h2d3c};
endmodule
`default_nettype wire

// ===== tb/program_sequencer_and_memory_map_tb.sv
/*
 Self-checking bench for the program sequencer: APB master, command
 driver and interrupt stimulus, with the ROM model on the far side.
 Assumes the package constants and the one-cycle dummy after transfers.
*/
`timescale 1ns/1ns
`default_nettype none
module program_sequencer_and_memory_map_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic cmd_valid = 1'b0;
    logic clk_en = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmd_ready;
    seq_pkg::seq_cmd_t cmd = '0;
    seq_pkg::irq_req_t irq = '0;
    logic [1:0] irq_ack;
    logic [15:0] rom_data;
    logic [12:0] sample_start_addr = 13'h0000;
    logic [12:0] prog_counter_bits;
    logic [16:0] rom_word_addr_lines;
    logic [17:0] rom_byte_addr_lines;
    logic [3:0] bank_select_bits;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int checked = 0;

    prog_sequencer u_prog_sequencer (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd(cmd), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .irq(irq), .irq_ack(irq_ack),
        .rom_data(rom_data), .sample_start_addr(sample_start_addr),
        .rom_word_addr_lines(rom_word_addr_lines),
        .rom_byte_addr_lines(rom_byte_addr_lines),
        .prog_counter_bits(prog_counter_bits),
        .bank_select_bits(bank_select_bits));
    rom_model u_rom_model (.word_addr(rom_word_addr_lines), .data(rom_data));

    always #2 pclk = ~pclk;

    function automatic logic [15:0] rom_word(input logic [16:0] a);
        return a[15:0] ^ {a[16], 15'h2d3c};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 32'h1, 32'(pready));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, {2'b00, i, 2'b00}, d);
    endtask

    task automatic rdk(input string what, input logic [7:0] i,
                       input logic [7:0] e);
        apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
        chk(what, {24'h0, e}, rd);
    endtask

    task automatic send(input seq_pkg::op_t op, input logic [12:0] opd,
                        input logic [7:0] dst, input logic [2:0] b);
        int n;
        @(posedge pclk);
        cmd <= {op, opd, dst, b};
        cmd_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 20);
        chk("cmd_ready", 32'h1, 32'(cmd_ready));
        cmd_valid <= 1'b0;
    endtask

    task automatic pc_is(input logic [12:0] e);
        @(negedge pclk);
        chk("pc", 32'(e), 32'(prog_counter_bits));
    endtask

    task automatic take_irq(input logic [1:0] ack, input logic [12:0] vec);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (irq_ack === 2'b00 && n < 20);
        irq <= '0;
        chk("irq ack", 32'(ack), 32'(irq_ack));
        pc_is(vec);
        chk("bank kept", 32'h5, 32'(bank_select_bits));
    endtask

    task automatic t_reset();
        pc_is(seq_pkg::RESET_PC);
        chk("bank", 32'(seq_pkg::RESET_BANK), 32'(bank_select_bits));
        chk("word addr", 32'h0, 32'(rom_word_addr_lines));
        done("reset");
    endtask

    task automatic t_flow();
        send(seq_pkg::OP_JUMP, 13'h1234, 8'h00, 3'h0);
        pc_is(13'h1234);
        send(seq_pkg::OP_SKIP, 13'h0000, 8'h00, 3'h0);
        pc_is(13'h1236);
        chk("dummy", 32'h0, 32'(cmd_ready));
        wr(seq_pkg::IDX_PCL, 8'h77);
        pc_is(13'h1277);
        wr(seq_pkg::IDX_BANK, 8'h05);
        @(negedge pclk);
        chk("bank early", 32'h0, 32'(bank_select_bits));
        send(seq_pkg::OP_NEXT, 13'h0000, 8'h00, 3'h0);
        pc_is(13'h1278);
        chk("bank late", 32'h5, 32'(bank_select_bits));
        repeat (2) @(negedge pclk);
        chk("word addr", 32'({4'h5, 13'h1278}),
            32'(rom_word_addr_lines));
        rdk("bank read", seq_pkg::IDX_BANK, 8'h00);
        done("flow");
    endtask

    task automatic t_stack();
        send(seq_pkg::OP_JUMP, 13'h0200, 8'h00, 3'h0);
        for (int i = 0; i < 9; i++) begin
            send(seq_pkg::OP_CALL, 13'h0300 + 13'(i * 16), 8'h00, 3'h0);
        end
        pc_is(13'h0380);
        @(posedge pclk);
        irq <= 5'b11100;
        repeat (10) begin
            @(posedge pclk);
            chk("ack while full", 2'b00, irq_ack);
        end
        send(seq_pkg::OP_RET, 13'h0000, 8'h00, 3'h0);
        take_irq(2'b01, seq_pkg::VEC_TMR0);
        send(seq_pkg::OP_RETURN_INT, 13'h0000, 8'h00, 3'h0);
        pc_is(13'h0371);
        for (int i = 6; i >= 0; i--) begin
            send(seq_pkg::OP_RET, 13'h0000, 8'h00, 3'h0);
            pc_is(13'h0301 + 13'(i * 16));
        end
        @(posedge pclk);
        irq <= 5'b10011;
        take_irq(2'b10, seq_pkg::VEC_TMR1);
        send(seq_pkg::OP_RETURN_INT, 13'h0000, 8'h00, 3'h0);
        pc_is(13'h0301);
        // Oldest return address was overwritten by the ninth call
        send(seq_pkg::OP_RET, 13'h0000, 8'h00, 3'h0);
        pc_is(13'h0371);
        done("stack");
    endtask

    task automatic t_table();
        wr(seq_pkg::IDX_TABLE_POINTER, 8'h34);
        send(seq_pkg::OP_JUMP, 13'h0a00, 8'h00, 3'h0);
        send(seq_pkg::OP_TABLE_READ_CURRENT_PAGE, 13'h0000, 8'h40, 3'h0);
        @(negedge pclk);
        chk("busy", 32'h0, 32'(cmd_ready));
        chk("page addr", 32'h0aa34, 32'(rom_word_addr_lines));
        @(negedge pclk);
        chk("ready", 32'h1, 32'(cmd_ready));
        rdk("low", 8'h40, 8'(rom_word(17'h0aa34)));
        rdk("high", seq_pkg::IDX_TABLE_HIGH_BYTE, 8'(rom_word(17'h0aa34) >> 8));
        wr(seq_pkg::IDX_TABLE_POINTER, 8'h9c);
        send(seq_pkg::OP_TABLE_READ_LAST_PAGE, 13'h0000, 8'h41, 3'h0);
        @(negedge pclk);
        chk("last addr", 32'h0bf9c, 32'(rom_word_addr_lines));
        wr(seq_pkg::IDX_TABLE_HIGH_BYTE, 8'h00);
        rdk("low", 8'h41, 8'(rom_word(17'h0bf9c)));
        rdk("high", seq_pkg::IDX_TABLE_HIGH_BYTE, 8'(rom_word(17'h0bf9c) >> 8));
        rdk("pointer", seq_pkg::IDX_TABLE_POINTER, 8'h9c);
        done("table");
    endtask

    task automatic t_memory();
        wr(8'h30, 8'h11);
        wr(8'hff, 8'h22);
        wr(8'h2c, 8'h55);
        wr(8'h25, 8'h66);
        rdk("gp low", 8'h30, 8'h11);
        rdk("gp high", 8'hff, 8'h22);
        rdk("reserved", 8'h2c, 8'h00);
        rdk("wave", 8'h25, 8'h66);
        wr(seq_pkg::IDX_PTR0, 8'h50);
        wr(seq_pkg::IDX_IND0, 8'ha5);
        rdk("direct", 8'h50, 8'ha5);
        wr(seq_pkg::IDX_PTR1, 8'h50);
        rdk("via ptr1", seq_pkg::IDX_IND1, 8'ha5);
        send(seq_pkg::OP_BSET, 13'h0000, 8'h50, 3'h1);
        rdk("bit set", 8'h50, 8'ha7);
        send(seq_pkg::OP_BCLR, 13'h0000, 8'h50, 3'h7);
        rdk("bit clear", 8'h50, 8'h27);
        apb(1'b0, 12'h401, 8'h00);
        chk("bad addr", 32'h1, 32'(err));
        done("memory");
    endtask

    task automatic t_sample();
        logic [12:0] v [2];
        v = '{13'h1abc, 13'h1fff};
        foreach (v[k]) begin
            @(posedge pclk);
            sample_start_addr <= v[k];
            repeat (3) @(negedge pclk);
            chk("byte addr", 32'({v[k], 5'h00}),
                32'(rom_byte_addr_lines));
        end
        done("sample");
    endtask

    task automatic t_freeze();
        logic [12:0] p;
        p = prog_counter_bits;
        @(posedge pclk);
        // A command offered while stalled must not be taken
        clk_en <= 1'b0;
        cmd <= {seq_pkg::OP_NEXT, 13'h0000, 8'h00, 3'h0};
        cmd_valid <= 1'b1;
        repeat (3) @(negedge pclk);
        chk("frozen pc", 32'(p), 32'(prog_counter_bits));
        chk("frozen ready", 32'h0, 32'(cmd_ready));
        @(posedge pclk);
        clk_en <= 1'b1;
        cmd_valid <= 1'b0;
        done("freeze");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_flow();
        t_stack();
        t_table();
        t_memory();
        t_sample();
        t_freeze();
        print_verdict();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #40000;
        n_mismatch++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
`default_nettype wire
